// file: addr_decoder.sv
// Purpose: splits the 64K space into program, RAM and peripheral regions
// Assumes: size selects already hold their programmed values
// Notes: purely combinational; region priority runs from the top of memory down
`timescale 1ns/10ps
`default_nettype none
module addr_decoder (
	decode_if.decoder dec
);
	import mmap_pkg::*;
	logic [15:0] rom_top; // last program byte
	logic [15:0] exp_base; // first expansion byte
	logic exp_on; // expansion RAM present
	logic [3:0] exs_step; // 512-byte steps below the limit

	// bounds follow the live size selects, so a write acts next cycle
	always_comb begin
		rom_top = {dec.mss[3:0], 12'h000} - 16'h0001; // [R4] [R25]
		exp_on = dec.exs[3:0] < EXS_NONE;
		exs_step = EXS_NONE - dec.exs[3:0];
		exp_base = EXP_LIMIT - {3'h0, exs_step, 9'h000}; // [R13] [R25]
	end

	// region pick, peripherals first
	always_comb begin
		if (in_range(dec.addr, SFR_BASE, SFR_END)) begin
			dec.region = RG_SFR; // [R15]
		end else if (in_range(dec.addr, HSR_BASE, HSR_END)) begin
			dec.region = RG_HSR;
		end else if (in_range(dec.addr, BUF_BASE, BUF_END)) begin
			dec.region = RG_BUF; // [R12]
		end else if (exp_on && in_range(dec.addr, exp_base, EXP_LIMIT - 16'h0001)) begin
			dec.region = RG_EXP; // [R13]
		end else if (dec.mss[3:0] != 4'h0 && dec.addr <= rom_top) begin
			dec.region = RG_ROM; // [R4]
		end else begin
			dec.region = RG_NONE;
		end
	end

	// sub-areas and access legality
	always_comb begin
		dec.vec_area = in_range(dec.addr, VEC_BASE, VEC_END); // [R5]
		dec.table_call_instr_area = in_range(dec.addr, TABLE_CALL_INSTR_BASE, TABLE_CALL_INSTR_END); // [R8]
		dec.fixed_area_call_instr_area = in_range(dec.addr, FIXED_AREA_CALL_INSTR_BASE, FIXED_AREA_CALL_INSTR_END); // [R9]
		dec.gpr_area = in_range(dec.addr, GPR_BASE, GPR_END); // [R10]
		// no fetch from fast RAM, stack only in fast RAM
		dec.fault = (dec.region == RG_NONE)
			|| (dec.kind == ACC_FETCH && dec.region == RG_HSR) // [R11]
			|| (dec.kind == ACC_STACK && dec.region != RG_HSR); // [R14]
	end
endmodule
`default_nettype wire

// file: core_mem_model.sv
// Purpose: byte memory on the far side of the core memory port
// Assumes: a read strobed in one cycle is answered in the next
// Notes: the data bus toggles when no read is due, so stale data never looks valid
`timescale 1ns/10ps
`default_nettype none
module core_mem_model (
	input wire logic clk,
	input wire logic [15:0] addr,
	input wire logic rd,
	input wire logic wr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata
);
	logic [7:0] mem [0:65535]; // full byte store
	// unwritten bytes hold the inverted low address, so a wrong fetch never looks real
	// vectors and table entries: low byte even, high byte odd
	initial begin
		for (int i = 0; i < 65536; i++) begin
			mem[i] = ~i[7:0];
		end
		mem[16'h0000] = 8'h34;
		mem[16'h0001] = 8'h12;
		mem[16'h0004] = 8'h78;
		mem[16'h0005] = 8'h56;
		mem[16'h0030] = 8'hbc;
		mem[16'h0031] = 8'h9a;
		mem[16'h003e] = 8'h21;
		mem[16'h003f] = 8'h43;
		mem[16'h0044] = 8'hcd;
		mem[16'h0045] = 8'hab;
		rdata = 8'h00;
	end
	// answer one cycle late, store writes at once
	always @(posedge clk) begin
		if (rd) begin
			rdata <= mem[addr];
		end else begin
			rdata <= ~rdata; // released bus
		end
		if (wr) begin
			mem[addr] = wdata;
		end
	end
endmodule
`default_nettype wire

// file: cpu_memory_map_control_bench.sv
// Purpose: self-checking bench of the memory map and control block
// Assumes: zero-wait APB, memory model answers reads one cycle late
// Notes: ends with a reset in mid-run so the reset vector, expansion size select and flags word must come back
`timescale 1ns/10ps
`default_nettype none
module cpu_memory_map_control_bench import mmap_pkg::*;;
	logic clk, srst, psel, penable, pwrite, pready, pslverr, op_ready, irq_req, irq_mask;
	logic irq_low, nmi_req, irq_ack, mem_rd, mem_wr, ie_out, va, ta, fa, ga, flt, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [15:0] core_addr, mem_addr, pc_out, op_data;
	logic [7:0] mem_wdata, mem_rdata;
	logic [2:0] op_len;
	logic [4:0] irq_slot;
	acc_t core_kind;
	region_t region;
	op_t op;
	int mismatches, n_compared, cycles;
	mmap_ctrl dut (.CLK_SYS(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .CORE_ADDR(core_addr), .CORE_KIND(core_kind),
		.CORE_REGION(region), .CORE_VEC_AREA(va), .CORE_TABLE_CALL_INSTR_AREA(ta),
		.CORE_FIXED_AREA_CALL_INSTR_AREA(fa), .CORE_GPR_AREA(ga), .CORE_FAULT(flt), .OP(op),
		.OP_LEN(op_len), .OP_DATA(op_data), .OP_READY(op_ready), .IRQ_REQ(irq_req),
		.IRQ_MASK(irq_mask), .IRQ_LOW_PRIO(irq_low), .IRQ_SLOT(irq_slot),
		.NMI_REQ(nmi_req), .IRQ_ACK(irq_ack), .MEM_ADDR(mem_addr), .MEM_RD(mem_rd),
		.MEM_WR(mem_wr), .MEM_WDATA(mem_wdata), .MEM_RDATA(mem_rdata), .PC_OUT(pc_out),
		.IE_OUT(ie_out));
	core_mem_model mdl (.clk(clk), .addr(mem_addr), .rd(mem_rd), .wr(mem_wr),
		.wdata(mem_wdata), .rdata(mem_rdata));
	// 100 ns clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// hang guard, far above the few hundred cycles needed
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			complete_run();
		end
	end
	task automatic complete_run;
		if (mismatches == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one APB transfer; request held until pready seen high at an edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(q, exp);
		chk(32'(e), 32'h0);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		chk(32'(e), 32'h0);
	endtask
	// flags are {vector, table call, fixed call, banks, fault}
	task automatic dec(input logic [15:0] a, input acc_t k, input region_t r,
		input logic [4:0] f);
		@(posedge clk);
		core_addr <= a;
		core_kind <= k;
		@(negedge clk);
		chk(32'(region), 32'(r));
		chk(32'({va, ta, fa, ga, flt}), 32'(f));
	endtask
	task automatic wait_rdy;
		do @(posedge clk); while (op_ready !== 1'b1);
		@(negedge clk);
	endtask
	task automatic do_op(input op_t o, input logic [15:0] d);
		@(posedge clk);
		op <= o;
		op_data <= d;
		do @(posedge clk); while (op_ready !== 1'b1);
		op <= OP_NONE;
		@(negedge clk);
	endtask
	// watch up to eight edges for an acknowledge
	task automatic irq_try(input logic exp);
		logic got;
		got = 1'b0;
		for (int i = 0; i < 8 && !got; i++) begin
			@(posedge clk);
			got = (irq_ack === 1'b1);
		end
		chk(32'(got), 32'(exp));
	endtask
	// main sequence
	initial begin
		{srst, psel, penable, pwrite, irq_req, irq_mask, irq_low, nmi_req} = 8'h80;
		{paddr, pwdata, core_addr, op_data, op_len, irq_slot} = '0;
		op_len = 3'h3;
		core_kind = ACC_DATA;
		op = OP_NONE;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		wait_rdy();
		chk(32'(pc_out), 32'h1234);
		chk(32'(ie_out), 32'h0);
		rd(OFS_MSS, 32'hcf);
		rd(OFS_EXS, 32'h0c);
		rd(OFS_FLAGS, 32'h02);
		apb(1'b0, 12'h018, 32'h0);
		chk(32'(e), 32'h1);
		dec(16'hefff, ACC_FETCH, RG_ROM, 5'h00);
		dec(16'hf400, ACC_DATA, RG_NONE, 5'h01);
		wr(OFS_MSS, 32'hcc);
		wr(OFS_EXS, 32'h0a);
		dec(16'hbfff, ACC_FETCH, RG_ROM, 5'h00);
		dec(16'hc000, ACC_FETCH, RG_NONE, 5'h01);
		dec(16'hf400, ACC_FETCH, RG_EXP, 5'h00);
		dec(16'hf3ff, ACC_DATA, RG_NONE, 5'h01);
		wr(OFS_MSS, 32'hcf);
		wr(OFS_EXS, 32'h08);
		dec(16'hefff, ACC_DATA, RG_ROM, 5'h00);
		dec(16'hf000, ACC_DATA, RG_EXP, 5'h00);
		dec(16'hf000, ACC_STACK, RG_EXP, 5'h01);
		dec(16'h003f, ACC_FETCH, RG_ROM, 5'h10);
		dec(16'h0040, ACC_FETCH, RG_ROM, 5'h08);
		dec(16'h007f, ACC_FETCH, RG_ROM, 5'h08);
		dec(16'h0800, ACC_FETCH, RG_ROM, 5'h04);
		dec(16'h1000, ACC_FETCH, RG_ROM, 5'h00);
		dec(16'hfadf, ACC_DATA, RG_BUF, 5'h00);
		dec(16'hfb00, ACC_FETCH, RG_HSR, 5'h01);
		dec(16'hfb00, ACC_STACK, RG_HSR, 5'h00);
		dec(16'hfee0, ACC_DATA, RG_HSR, 5'h02);
		// peripheral window is only decoded, never accessed at an empty address
		dec(16'hff00, ACC_DATA, RG_SFR, 5'h00);
		dec(16'hffff, ACC_DATA, RG_SFR, 5'h00);
		do_op(OP_ADV, 16'h0);
		chk(32'(pc_out), 32'h1237);
		do_op(OP_BRANCH, 16'h2000);
		chk(32'(pc_out), 32'h2000);
		do_op(OP_EI, 16'h0);
		chk(32'(ie_out), 32'h1);
		do_op(OP_DI, 16'h0);
		chk(32'(ie_out), 32'h0);
		// maskable refused while disabled, non-maskable still taken
		@(posedge clk);
		irq_slot <= 5'h02;
		irq_req <= 1'b1;
		irq_try(1'b0);
		nmi_req <= 1'b1;
		irq_try(1'b1);
		irq_req <= 1'b0;
		nmi_req <= 1'b0;
		wait_rdy();
		chk(32'(pc_out), 32'h5678);
		chk(32'(mdl.mem[16'hfeff]), 32'h02);
		rd(OFS_SP, 32'hfeff);
		do_op(OP_EI, 16'h0);
		@(posedge clk);
		irq_slot <= 5'h18;
		irq_mask <= 1'b1;
		irq_req <= 1'b1;
		irq_try(1'b0);
		irq_mask <= 1'b0;
		irq_try(1'b1);
		irq_req <= 1'b0;
		wait_rdy();
		chk(32'(ie_out), 32'h0);
		chk(32'(pc_out), 32'h9abc);
		chk(32'(mdl.mem[16'hfefe]), 32'h82);
		rd(OFS_SP, 32'hfefe);
		do_op(OP_POPF, 16'h0);
		wait_rdy();
		chk(32'(ie_out), 32'h1);
		rd(OFS_SP, 32'hfeff);
		// low priority source refused while the in-service flag is clear
		wr(OFS_FLAGS, 32'h80);
		@(posedge clk);
		irq_low <= 1'b1;
		irq_req <= 1'b1;
		irq_try(1'b0);
		irq_req <= 1'b0;
		do_op(OP_PUSHF, 16'h0);
		wait_rdy();
		chk(32'(mdl.mem[16'hfefe]), 32'h80);
		do_op(OP_BRK, 16'h0);
		wait_rdy();
		chk(32'(pc_out), 32'h4321);
		chk(32'(mdl.mem[16'hfefd]), 32'h80);
		do_op(OP_BREAK_RETURN_INSTR, 16'h3000);
		wait_rdy();
		chk(32'(pc_out), 32'h3000);
		chk(32'(ie_out), 32'h1);
		do_op(OP_DI, 16'h0);
		do_op(OP_IRQ_RETURN_INSTR, 16'h3100);
		wait_rdy();
		chk(32'(pc_out), 32'h3100);
		chk(32'(ie_out), 32'h1);
		rd(OFS_SP, 32'hfeff);
		do_op(OP_FIXED_AREA_CALL_INSTR, 16'h0123);
		chk(32'(pc_out), 32'h0923);
		do_op(OP_TABLE_CALL_INSTR, 16'h0002);
		wait_rdy();
		chk(32'(pc_out), 32'habcd);
		apb(1'b1, OFS_SP, 32'hf000);
		chk(32'(e), 32'h1);
		rd(OFS_SP, 32'hfeff);
		// reset in mid-run: reset vector, expansion size select and flags word come back
		@(posedge clk);
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		wait_rdy();
		chk(32'(pc_out), 32'h1234);
		rd(OFS_EXS, 32'h0c);
		rd(OFS_FLAGS, 32'h02);
		complete_run();
	end
endmodule
`default_nettype wire

// file: decode_if.sv
// Purpose: carries one address decode between the control block and the decoder
// Assumes: combinational decode within one cycle
// Notes: size selects travel with the address so the decoder holds no state
`timescale 1ns/10ps
`default_nettype none
interface decode_if;
	import mmap_pkg::*;
	logic [7:0] mss; // memory size select value
	logic [7:0] exs; // expansion size select value
	logic [15:0] addr; // address under decode
	acc_t kind; // data, fetch or stack
	region_t region; // decoded region
	logic vec_area; // inside the vector table
	logic table_call_instr_area; // inside the table-call table
	logic fixed_area_call_instr_area; // inside the fixed call area
	logic gpr_area; // inside the register banks
	logic fault; // access not allowed here
	modport requester (output mss, exs, addr, kind,
		input region, vec_area, table_call_instr_area, fixed_area_call_instr_area, gpr_area, fault);
	modport decoder (input mss, exs, addr, kind,
		output region, vec_area, table_call_instr_area, fixed_area_call_instr_area, gpr_area, fault);
endinterface
`default_nettype wire

// file: mmap_ctrl.sv
// Purpose: size selects, program counter, flags word and stack pointer of the core
// Assumes: one-cycle read latency on the memory port, zero-wait APB
// Notes: core operations win over APB writes to the same register in one cycle
//
// The register offsets and the APB register port were decided locally.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// [R1] size selects reset to cfh and 0ch
// [R2] small part: software writes cch and 0ah
// [R3] large part: software writes cfh and 08h
// [R4] program memory ends at bfffh or efffh
// [R5] vectors occupy 0000h through 003fh
// [R6] vector low byte even, high byte odd
// [R7] fixed vector slot per interrupt source
// [R8] table call entries at 0040h to 007fh
// [R9] fixed call targets 0800h to 0fffh only
// [R10] register banks at fee0h to feffh
// [R11] no instruction fetch from fast RAM
// [R12] buffer RAM at fac0h to fadfh
// [R13] expansion RAM at f400h or f000h up
// [R14] expansion RAM never used as stack
// [R15] peripheral registers at ff00h to ffffh
// [R16] software avoids unassigned peripheral addresses
// [R17] counter advances by length or loads branch
// [R18] reset loads counter from vector 0000h
// [R19] flags pushed on entry, popped on return
// [R20] flags word resets to 02h
// [R21] enable clear refuses all but non-maskable
// [R22] enabled: priority and mask gate acceptance
// [R23] enable cleared by mask, acknowledge; set otherwise
// [R24] stack pointer predecrements, postincrements
// [R25] decode follows size selects next cycle
module mmap_ctrl (
	input wire logic CLK_SYS,
	input wire logic SRST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic [15:0] CORE_ADDR,
	input wire mmap_pkg::acc_t CORE_KIND,
	output mmap_pkg::region_t CORE_REGION,
	output logic CORE_VEC_AREA,
	output logic CORE_TABLE_CALL_INSTR_AREA,
	output logic CORE_FIXED_AREA_CALL_INSTR_AREA,
	output logic CORE_GPR_AREA,
	output logic CORE_FAULT,
	input wire mmap_pkg::op_t OP,
	input wire logic [2:0] OP_LEN,
	input wire logic [15:0] OP_DATA,
	output logic OP_READY,
	input wire logic IRQ_REQ,
	input wire logic IRQ_MASK,
	input wire logic IRQ_LOW_PRIO,
	input wire logic [4:0] IRQ_SLOT,
	input wire logic NMI_REQ,
	output logic IRQ_ACK,
	output logic [15:0] MEM_ADDR,
	output logic MEM_RD,
	output logic MEM_WR,
	output logic [7:0] MEM_WDATA,
	input wire logic [7:0] MEM_RDATA,
	output logic [15:0] PC_OUT,
	output logic IE_OUT
);
	import mmap_pkg::*;
	decode_if dec (); // link to the region decoder
	logic [7:0] mss_q; // memory size select
	logic [7:0] exs_q; // expansion size select
	logic [15:0] pc_q; // program counter
	logic [7:0] flags_q; // flags word
	logic [15:0] sp_q; // stack pointer
	state_t state_q; // sequencer state
	logic [15:0] vec_addr_q; // table entry being fetched
	logic vec_pend_q; // table fetch follows the push
	logic [15:0] mem_addr_q; // memory address out
	logic mem_rd_q; // memory read strobe out
	logic mem_wr_q; // memory write strobe out
	logic [7:0] mem_wdata_q; // memory write data out
	logic [31:0] prdata_q; // read data held for the access phase
	logic apb_acc; // access phase
	logic apb_wr; // write taking effect now
	logic mapped; // address hits a register
	logic sp_ok; // written stack value lies in fast RAM or is ff00h just above it
	logic idle; // sequencer can take an operation
	logic take_irq; // interrupt accepted this cycle
	logic op_go; // operation accepted this cycle
	logic start_push; // flags push begins
	logic start_pop; // flags pop begins
	logic start_vec; // direct table fetch begins
	logic [15:0] start_vec_addr; // where that fetch reads
	logic [15:0] irq_vec_addr; // slot of the accepted source

	// region decoder for the core's own accesses
	addr_decoder u_dec (
		.dec(dec)
	);

	// decode port wiring
	always_comb begin
		dec.mss = mss_q;
		dec.exs = exs_q;
		dec.addr = CORE_ADDR;
		dec.kind = CORE_KIND;
		CORE_REGION = dec.region;
		CORE_VEC_AREA = dec.vec_area;
		CORE_TABLE_CALL_INSTR_AREA = dec.table_call_instr_area;
		CORE_FIXED_AREA_CALL_INSTR_AREA = dec.fixed_area_call_instr_area;
		CORE_GPR_AREA = dec.gpr_area;
		CORE_FAULT = dec.fault;
	end

	// apb decode; zero wait states, so pready is simply high
	always_comb begin
		apb_acc = PSEL && PENABLE;
		mapped = (PADDR == OFS_MSS) || (PADDR == OFS_EXS) || (PADDR == OFS_PC)
			|| (PADDR == OFS_FLAGS) || (PADDR == OFS_SP) || (PADDR == OFS_STATE);
		// stack outside fast RAM would land in expansion RAM or worse
		sp_ok = in_range(PWDATA[15:0], HSR_BASE, HSR_END + 16'h0001); // [R14]
		PREADY = 1'b1;
		PSLVERR = apb_acc && (!mapped || (PWRITE && PADDR == OFS_SP && !sp_ok));
		apb_wr = apb_acc && PWRITE && !PSLVERR;
		PRDATA = prdata_q;
	end

	// read data is captured in the setup cycle so it comes from a flop
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			prdata_q <= 32'h0000_0000;
		end else if (PSEL && !PENABLE && !PWRITE) begin
			unique case (PADDR)
				OFS_MSS: prdata_q <= {24'h00_0000, mss_q};
				OFS_EXS: prdata_q <= {24'h00_0000, exs_q};
				OFS_PC: prdata_q <= {16'h0000, pc_q};
				OFS_FLAGS: prdata_q <= {24'h00_0000, flags_q};
				OFS_SP: prdata_q <= {16'h0000, sp_q};
				OFS_STATE: prdata_q <= {25'h000_0000, state_q};
				default: prdata_q <= 32'h0000_0000;
			endcase
		end
	end

	// size selects; decode picks new values up on the next cycle
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			mss_q <= MSS_RESET; // [R1]
			exs_q <= EXS_RESET; // [R1]
		end else if (apb_wr && PADDR == OFS_MSS) begin
			mss_q <= PWDATA[7:0]; // [R25]
		end else if (apb_wr && PADDR == OFS_EXS) begin
			exs_q <= PWDATA[7:0]; // [R25]
		end
	end

	// acceptance and operation start decisions
	always_comb begin
		idle = state_q == S_IDLE;
		// low priority sources wait while a high one is in service
		take_irq = idle && (NMI_REQ || (IRQ_REQ && flags_q[IE_BIT] && !IRQ_MASK
			&& (!IRQ_LOW_PRIO || flags_q[ISP_BIT]))); // [R21] [R22]
		op_go = idle && !take_irq && OP != OP_NONE;
		irq_vec_addr = VEC_BASE | {10'h000, IRQ_SLOT, 1'b0}; // [R7]
		start_push = take_irq || (op_go && (OP == OP_PUSHF || OP == OP_BRK)); // [R19]
		start_pop = op_go && (OP == OP_POPF || OP == OP_IRQ_RETURN_INSTR || OP == OP_BREAK_RETURN_INSTR); // [R19]
		start_vec = op_go && OP == OP_TABLE_CALL_INSTR;
		start_vec_addr = TABLE_CALL_INSTR_BASE | {10'h000, OP_DATA[4:0], 1'b0}; // [R8]
		OP_READY = idle && !take_irq;
		IRQ_ACK = take_irq;
	end

	// sequencer for pushes, pops and two-byte table fetches
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			state_q <= S_VEC_LO; // [R18]
			vec_addr_q <= VEC_BASE;
			vec_pend_q <= 1'b0;
			mem_addr_q <= VEC_BASE; // [R18]
			mem_rd_q <= 1'b1;
			mem_wr_q <= 1'b0;
			mem_wdata_q <= 8'h00;
		end else begin
			unique case (state_q)
				S_IDLE: begin
					mem_rd_q <= 1'b0;
					mem_wr_q <= 1'b0;
					if (start_push) begin
						// predecrement, then write in the push cycle
						mem_addr_q <= sp_q - 16'h0001; // [R24]
						mem_wr_q <= 1'b1;
						mem_wdata_q <= flags_q; // [R19]
						vec_pend_q <= take_irq || OP == OP_BRK;
						vec_addr_q <= take_irq ? irq_vec_addr : BRK_VEC; // [R7]
						state_q <= S_PUSH;
					end else if (start_pop) begin
						mem_addr_q <= sp_q;
						mem_rd_q <= 1'b1;
						state_q <= S_POP_RD;
					end else if (start_vec) begin
						mem_addr_q <= start_vec_addr;
						vec_addr_q <= start_vec_addr;
						mem_rd_q <= 1'b1;
						state_q <= S_VEC_LO;
					end
				end
				S_PUSH: begin
					mem_wr_q <= 1'b0;
					if (vec_pend_q) begin
						mem_addr_q <= vec_addr_q;
						mem_rd_q <= 1'b1;
						state_q <= S_VEC_LO;
					end else begin
						state_q <= S_IDLE;
					end
				end
				S_POP_RD: begin
					mem_rd_q <= 1'b0;
					state_q <= S_POP_WB;
				end
				S_POP_WB: begin
					state_q <= S_IDLE;
				end
				S_VEC_LO: begin
					// high byte sits at the following odd address
					mem_addr_q <= vec_addr_q + 16'h0001; // [R6]
					mem_rd_q <= 1'b1;
					state_q <= S_VEC_HI;
				end
				S_VEC_HI: begin
					mem_rd_q <= 1'b0;
					state_q <= S_VEC_FIN;
				end
				S_VEC_FIN: begin
					vec_pend_q <= 1'b0;
					state_q <= S_IDLE;
				end
				default: begin
					state_q <= S_IDLE;
					mem_rd_q <= 1'b0;
					mem_wr_q <= 1'b0;
				end
			endcase
		end
	end

	// memory port comes straight from flops
	always_comb begin
		MEM_ADDR = mem_addr_q;
		MEM_RD = mem_rd_q;
		MEM_WR = mem_wr_q;
		MEM_WDATA = mem_wdata_q;
		PC_OUT = pc_q;
		IE_OUT = flags_q[IE_BIT];
	end

	// program counter; table bytes land low first, high next
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			pc_q <= 16'h0000;
		end else if (state_q == S_VEC_HI) begin
			pc_q[7:0] <= MEM_RDATA; // [R6] [R18]
		end else if (state_q == S_VEC_FIN) begin
			pc_q[15:8] <= MEM_RDATA; // [R6] [R18]
		end else if (op_go && OP == OP_ADV) begin
			pc_q <= pc_q + {13'h0000, OP_LEN}; // [R17]
		end else if (op_go && (OP == OP_BRANCH || OP == OP_IRQ_RETURN_INSTR || OP == OP_BREAK_RETURN_INSTR)) begin
			pc_q <= OP_DATA; // [R17]
		end else if (op_go && OP == OP_FIXED_AREA_CALL_INSTR) begin
			pc_q <= FIXED_AREA_CALL_INSTR_BASE | {5'h00, OP_DATA[10:0]}; // [R9]
		end else if (apb_wr && PADDR == OFS_PC && idle) begin
			pc_q <= PWDATA[15:0]; // [R17]
		end
	end

	// flags word; acknowledge clearing the enable wins over everything
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			flags_q <= FLAGS_RESET; // [R20]
		end else if (take_irq || (op_go && (OP == OP_DI || OP == OP_BRK))) begin
			flags_q[IE_BIT] <= 1'b0; // [R23]
		end else if (op_go && OP == OP_EI) begin
			flags_q[IE_BIT] <= 1'b1; // [R23]
		end else if (state_q == S_POP_WB) begin
			flags_q <= MEM_RDATA; // [R19]
		end else if (apb_wr && PADDR == OFS_FLAGS) begin
			flags_q <= PWDATA[7:0];
		end
	end

	// stack pointer
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			sp_q <= SP_RESET;
		end else if (start_push) begin
			sp_q <= sp_q - 16'h0001; // [R24]
		end else if (state_q == S_POP_WB) begin
			sp_q <= sp_q + 16'h0001; // [R24]
		end else if (apb_wr && PADDR == OFS_SP) begin
			sp_q <= PWDATA[15:0];
		end
	end

	a_reset_sizes: assert property (@(posedge CLK_SYS) $past(SRST) |-> // [R1]
		mss_q == MSS_RESET && exs_q == EXS_RESET && flags_q == FLAGS_RESET)
		else $error("size selects or flags wrong after reset");
	a_reset_fetch: assert property (@(posedge CLK_SYS) $past(SRST) && !SRST |-> // [R18]
		mem_rd_q && mem_addr_q == VEC_BASE ##1 mem_addr_q == VEC_BASE + 16'h0001)
		else $error("reset vector not fetched from the first table word");
	a_vec_pair: assert property (@(posedge CLK_SYS) disable iff (SRST) // [R6]
		state_q == S_VEC_LO |=> state_q == S_VEC_HI
		&& mem_addr_q == $past(mem_addr_q) + 16'h0001)
		else $error("vector high byte not read from the next address");
	a_pc_advance: assert property (@(posedge CLK_SYS) disable iff (SRST) // [R17]
		op_go && OP == OP_ADV |=> pc_q == $past(pc_q) + {13'h0000, $past(OP_LEN)})
		else $error("program counter did not advance by the length");
	a_fixed_area_call_instr_range: assert property (@(posedge CLK_SYS) disable iff (SRST) // [R9]
		op_go && OP == OP_FIXED_AREA_CALL_INSTR |=> in_range(pc_q, FIXED_AREA_CALL_INSTR_BASE, FIXED_AREA_CALL_INSTR_END))
		else $error("fixed call left its area");
	a_ie_refuse: assert property (@(posedge CLK_SYS) disable iff (SRST) // [R21]
		!flags_q[IE_BIT] && !NMI_REQ |-> !IRQ_ACK)
		else $error("maskable interrupt taken while disabled");
	a_ie_ack_clear: assert property (@(posedge CLK_SYS) disable iff (SRST) // [R23]
		IRQ_ACK |=> !flags_q[IE_BIT] && state_q == S_PUSH && mem_wr_q)
		else $error("acknowledge did not clear enable and push flags");
	a_push_predec: assert property (@(posedge CLK_SYS) disable iff (SRST) // [R24]
		start_push |=> sp_q == $past(sp_q) - 16'h0001 && mem_addr_q == sp_q)
		else $error("stack push not predecremented");
	a_pop_postinc: assert property (@(posedge CLK_SYS) disable iff (SRST) // [R24]
		start_pop |=> mem_addr_q == $past(sp_q) ##2 sp_q == $past(sp_q, 3) + 16'h0001)
		else $error("stack pop not postincremented");
	a_size_follow: assert property (@(posedge CLK_SYS) disable iff (SRST) // [R25]
		apb_wr && PADDR == OFS_MSS |=> mss_q == $past(PWDATA[7:0]))
		else $error("memory size select not updated");
	a_low_prio: assert property (@(posedge CLK_SYS) disable iff (SRST) // [R22]
		IRQ_REQ && IRQ_LOW_PRIO && !flags_q[ISP_BIT] && !NMI_REQ |-> !IRQ_ACK)
		else $error("low priority source taken while a high one is in service");
	a_irq_slot: assert property (@(posedge CLK_SYS) disable iff (SRST) // [R7]
		IRQ_ACK |=> vec_pend_q && vec_addr_q == {10'h000, $past(IRQ_SLOT), 1'b0})
		else $error("interrupt vector not taken from the source slot");
	a_fetch_fault: assert property (@(posedge CLK_SYS) // [R11]
		CORE_KIND == ACC_FETCH && CORE_REGION == RG_HSR |-> CORE_FAULT)
		else $error("instruction fetch from fast RAM not flagged");
	a_stack_fault: assert property (@(posedge CLK_SYS) // [R14]
		CORE_KIND == ACC_STACK && CORE_REGION == RG_EXP |-> CORE_FAULT)
		else $error("stack access to expansion RAM not flagged");
endmodule
`default_nettype wire

// file: mmap_pkg.sv
// Purpose: shared constants and types for the memory map and control block
// Assumes: 16-bit core address space, 8-bit data, APB register access
// Notes: every address bound and register offset lives here, with the reset values of the size selects, flags word and stack pointer
package mmap_pkg;
	// reset values of the size selects, flags word and stack pointer
	localparam logic [7:0] MSS_RESET = 8'hcf;
	localparam logic [7:0] EXS_RESET = 8'h0c;
	localparam logic [7:0] FLAGS_RESET = 8'h02;
	localparam logic [15:0] SP_RESET = 16'hff00;
	// flags word bit positions
	localparam int IE_BIT = 7;
	localparam int ISP_BIT = 1;
	// program memory areas
	localparam logic [15:0] VEC_BASE = 16'h0000;
	localparam logic [15:0] VEC_END = 16'h003f;
	localparam logic [15:0] TABLE_CALL_INSTR_BASE = 16'h0040;
	localparam logic [15:0] TABLE_CALL_INSTR_END = 16'h007f;
	localparam logic [15:0] FIXED_AREA_CALL_INSTR_BASE = 16'h0800;
	localparam logic [15:0] FIXED_AREA_CALL_INSTR_END = 16'h0fff;
	// fixed vector slots
	localparam logic [15:0] WDT_VEC = 16'h0004;
	localparam logic [15:0] ADC_VEC = 16'h0030;
	localparam logic [15:0] BRK_VEC = 16'h003e;
	// data memory areas
	localparam logic [15:0] EXP_LIMIT = 16'hf800;
	localparam logic [15:0] BUF_BASE = 16'hfac0;
	localparam logic [15:0] BUF_END = 16'hfadf;
	localparam logic [15:0] HSR_BASE = 16'hfb00;
	localparam logic [15:0] HSR_END = 16'hfeff;
	localparam logic [15:0] GPR_BASE = 16'hfee0;
	localparam logic [15:0] GPR_END = 16'hfeff;
	localparam logic [15:0] SFR_BASE = 16'hff00;
	localparam logic [15:0] SFR_END = 16'hffff;
	// expansion size code with no expansion RAM; each code step is 512 bytes
	localparam logic [3:0] EXS_NONE = 4'hc;
	// register byte offsets on the APB
	localparam logic [11:0] OFS_MSS = 12'h000;
	localparam logic [11:0] OFS_EXS = 12'h004;
	localparam logic [11:0] OFS_PC = 12'h008;
	localparam logic [11:0] OFS_FLAGS = 12'h00c;
	localparam logic [11:0] OFS_SP = 12'h010;
	localparam logic [11:0] OFS_STATE = 12'h014;
	// kind of core access
	typedef enum logic [1:0] {ACC_DATA = 2'h0, ACC_FETCH = 2'h1, ACC_STACK = 2'h2} acc_t;
	// decoded region, one-hot
	typedef enum logic [5:0] {RG_NONE = 6'h01, RG_ROM = 6'h02, RG_EXP = 6'h04,
		RG_BUF = 6'h08, RG_HSR = 6'h10, RG_SFR = 6'h20} region_t;
	// core sequencing operations
	typedef enum logic [3:0] {OP_NONE = 4'h0, OP_ADV = 4'h1, OP_BRANCH = 4'h2, OP_DI = 4'h3,
		OP_EI = 4'h4, OP_PUSHF = 4'h5, OP_POPF = 4'h6, OP_IRQ_RETURN_INSTR = 4'h7, OP_BREAK_RETURN_INSTR = 4'h8,
		OP_BRK = 4'h9, OP_TABLE_CALL_INSTR = 4'ha, OP_FIXED_AREA_CALL_INSTR = 4'hb} op_t;
	// sequencer states, one-hot
	typedef enum logic [6:0] {S_IDLE = 7'h01, S_PUSH = 7'h02, S_POP_RD = 7'h04,
		S_POP_WB = 7'h08, S_VEC_LO = 7'h10, S_VEC_HI = 7'h20, S_VEC_FIN = 7'h40} state_t;
	// inclusive range test
	function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
		input logic [15:0] hi);
		return (a >= lo) && (a <= hi);
	endfunction
endpackage
